//--- inc/tff_pkg.sv
package tff_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Buffer geometry
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned DEPTH       = 8;
    localparam int unsigned PTR_W       = 3;
    localparam int unsigned CNT_W       = 4;
    localparam logic [3:0]  DEPTH_CNT   = 4'h8;

    // Write to valid latency in cycles, one less is spent in the delay line
    localparam int unsigned WR_TO_VALID = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the APB
    localparam int unsigned ADDR_W      = 12;
    localparam logic [11:0] CTRL_OFS    = 12'h000;
    localparam logic [11:0] STATUS_OFS  = 12'h004;

    // Control fields
    localparam int unsigned LOW_LSB     = 0;
    localparam int unsigned HIGH_LSB    = 8;
    localparam logic [3:0]  LOW_RST     = 4'h2;
    localparam logic [3:0]  HIGH_RST    = 4'h7;

    // Status fields
    localparam int unsigned CNT_LSB     = 0;
    localparam int unsigned VALID_BIT   = 8;
    localparam int unsigned LEVEL_BIT   = 9;
    localparam int unsigned HIGH_BIT    = 10;
    localparam int unsigned FULL_BIT    = 11;
    localparam int unsigned MATURE_LSB  = 16;

endpackage

//--- hdl/tff_mem.sv
`timescale 1ns/1ps
module tff_mem (
    input  wire logic                            sys_clk_i,  // System clock
    input  wire logic                            rst_b_i,    // Sync reset, active low
    input  wire logic                            we_i,       // Write strobe
    input  wire logic [tff_pkg::PTR_W-1:0]       waddr_i,    // Write address
    input  wire logic [tff_pkg::DATA_W-1:0]      wdata_i,    // Write data
    input  wire logic                            re_i,       // Read enable
    input  wire logic [tff_pkg::PTR_W-1:0]       raddr_i,    // Read address
    output logic      [tff_pkg::DATA_W-1:0]      rdata_o     // Registered read data
);

    logic [tff_pkg::DATA_W-1:0] store [tff_pkg::DEPTH];

    // Storage has no reset, only the read register does
    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            store[waddr_i] <= wdata_i;
        end
    end

    // Read register holds while re_i is low, which keeps the last read value
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (re_i) begin
            rdata_o <= store[raddr_i];
        end
    end

endmodule

//--- hdl/tff_top.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module tff_top (
    input  wire logic                            sys_clk_i,   // System clock, 125 MHz
    input  wire logic                            rst_b_i,     // Sync reset, active low
    input  wire logic                            wr_i,        // Write strobe
    input  wire logic [tff_pkg::DATA_W-1:0]      wr_data_i,   // Write data
    output logic                                 wr_ready_o,  // Room for a write
    input  wire logic                            rd_ack_i,    // Read acknowledge
    output logic      [tff_pkg::DATA_W-1:0]      rd_data_o,   // Head data
    output logic                                 valid_o,     // Head data valid
    output logic                                 level_o,     // Count at or above low
    output logic                                 high_o,      // Count at or above high
    input  wire logic                            psel_i,      // APB select
    input  wire logic                            penable_i,   // APB enable
    input  wire logic                            pwrite_i,    // APB direction
    input  wire logic [tff_pkg::ADDR_W-1:0]      paddr_i,     // APB byte address
    input  wire logic [31:0]                     pwdata_i,    // APB write data
    input  wire logic [3:0]                      pstrb_i,     // APB byte strobes
    output logic      [31:0]                     prdata_o,    // APB read data
    output logic                                 pready_o,    // APB ready
    output logic                                 pslverr_o    // APB error
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [tff_pkg::CNT_W-1:0]  cnt;
    logic [tff_pkg::CNT_W-1:0]  next_cnt;
    logic [tff_pkg::CNT_W-1:0]  mature;
    logic [tff_pkg::CNT_W-1:0]  next_mature;
    logic [tff_pkg::PTR_W-1:0]  wptr;
    logic [tff_pkg::PTR_W-1:0]  rptr;
    logic [tff_pkg::PTR_W-1:0]  next_rptr;
    logic                       next_valid;
    logic                       wr_acc;
    logic                       rd_acc;
    logic                       wr_d1;
    logic                       wr_d2;
    logic [3:0]                 low_lim;
    logic [3:0]                 high_lim;
    logic                       apb_setup;
    logic                       apb_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Threshold compare, shared by the level and high flags
    function automatic logic lim_hit(input logic [3:0] count, input logic [3:0] lim);
        lim_hit = (count >= lim);
    endfunction

    // Address decode, used by the error answer only; the read mux compares the offsets itself
    function automatic logic addr_known(input logic [tff_pkg::ADDR_W-1:0] addr);
        addr_known = (addr == tff_pkg::CTRL_OFS) || (addr == tff_pkg::STATUS_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Accepted strobes

    // A write while full is dropped; wr_ready_o warns the producer beforehand
    assign wr_acc = wr_i && (cnt != tff_pkg::DEPTH_CNT);
    // An acknowledge against a low valid is ignored rather than corrupting state
    assign rd_acc = rd_ack_i && valid_o;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state terms

    // Occupancy moves at once on both write and read
    always_comb begin
        next_cnt = cnt;
        if (wr_acc && !rd_acc) begin
            next_cnt = cnt + 4'h1;
        end else if (rd_acc && !wr_acc) begin
            next_cnt = cnt - 4'h1;
        end
    end

    // Entries become readable only once they leave the write delay line
    always_comb begin
        next_mature = mature;
        if (wr_d2 && !rd_acc) begin
            next_mature = mature + 4'h1;
        end else if (rd_acc && !wr_d2) begin
            next_mature = mature - 4'h1;
        end
    end

    assign next_rptr  = rptr + {{(tff_pkg::PTR_W-1){1'b0}}, rd_acc};
    // Valid needs a mature head, so young writes behind a read leave it low
    assign next_valid = (next_mature != 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Write delay line

    // Two stages plus the valid flop make the three-cycle write latency
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wr_d1 <= 1'b0;
            wr_d2 <= 1'b0;
        end else begin
            wr_d1 <= wr_acc;
            wr_d2 <= wr_d1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointers and counters

    // Write pointer wraps naturally at the power-of-two depth
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wptr <= '0;
        end else if (wr_acc) begin
            wptr <= wptr + 3'h1;
        end
    end

    // Read pointer follows accepted acknowledges only
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rptr <= '0;
        end else begin
            rptr <= next_rptr;
        end
    end

    // Occupancy
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // Count of entries old enough to be presented
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            mature <= '0;
        end else begin
            mature <= next_mature;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags

    // Valid uses the long path, level and high the short one, so they can
    // disagree for a few cycles after a write into an empty buffer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            valid_o <= 1'b0;
            level_o <= 1'b0;
            high_o  <= 1'b0;
        end else begin
            valid_o <= next_valid;
            level_o <= lim_hit(next_cnt, low_lim);
            high_o  <= lim_hit(next_cnt, high_lim);
        end
    end

    // Ready reflects the count, so it is honest in the cycle it is seen
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            wr_ready_o <= 1'b0;
        end else begin
            wr_ready_o <= (next_cnt != tff_pkg::DEPTH_CNT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    // Read data loads only when the head after this edge is valid, so the bus
    // holds the last read value when valid falls
    tff_mem u_mem (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .we_i      (wr_acc),
        .waddr_i   (wptr),
        .wdata_i   (wr_data_i),
        .re_i      (next_valid),
        .raddr_i   (next_rptr),
        .rdata_o   (rd_data_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    assign apb_setup = psel_i && !penable_i;
    assign apb_wr    = psel_i && penable_i && pwrite_i && pready_o;

    // Fixed zero-wait answer: ready in every access phase
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= apb_setup;
        end
    end

    // Unmapped addresses answer with an error and read as zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= apb_setup && !addr_known(paddr_i);
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            prdata_o <= '0;
        end else if (apb_setup && !pwrite_i && paddr_i == tff_pkg::CTRL_OFS) begin
            prdata_o <= '0;
            prdata_o[tff_pkg::LOW_LSB +: 4]  <= low_lim;
            prdata_o[tff_pkg::HIGH_LSB +: 4] <= high_lim;
        end else if (apb_setup && !pwrite_i && paddr_i == tff_pkg::STATUS_OFS) begin
            prdata_o <= '0;
            prdata_o[tff_pkg::CNT_LSB +: 4]    <= cnt;
            prdata_o[tff_pkg::VALID_BIT]       <= valid_o;
            prdata_o[tff_pkg::LEVEL_BIT]       <= level_o;
            prdata_o[tff_pkg::HIGH_BIT]        <= high_o;
            prdata_o[tff_pkg::FULL_BIT]        <= (cnt == tff_pkg::DEPTH_CNT);
            prdata_o[tff_pkg::MATURE_LSB +: 4] <= mature;
        end else if (apb_setup) begin
            prdata_o <= '0;
        end
    end

    // Limits live in byte lanes 0 and 1; no clamp, software picks sane values
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            low_lim  <= tff_pkg::LOW_RST;
            high_lim <= tff_pkg::HIGH_RST;
        end else if (apb_wr && paddr_i == tff_pkg::CTRL_OFS) begin
            if (pstrb_i[0]) begin
                low_lim <= pwdata_i[tff_pkg::LOW_LSB +: 4];
            end
            if (pstrb_i[1]) begin
                high_lim <= pwdata_i[tff_pkg::HIGH_LSB +: 4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Empty buffer: valid appears on the third edge after the write
    v_rise_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_acc && cnt == 4'h0 |-> ##3 valid_o)
        else $error("valid did not rise three cycles after first write");

    // Empty buffer: valid stays low for the two cycles in between
    empty_wait_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_acc && cnt == 4'h0 |-> !valid_o ##1 !valid_o ##1 !valid_o)
        else $error("valid rose early after first write");

    // First word reaches the bus together with valid
    q_lat_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_acc && cnt == 4'h0 |-> ##3 (rd_data_o == $past(wr_data_i, 3)))
        else $error("output data late or wrong after first write");

    // A lone read lowers the count by one at the next edge
    rd_upd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        rd_acc && !wr_acc |=> (cnt == $past(cnt) - 4'h1) && !$stable(rptr))
        else $error("read did not update state in one cycle");

    // Level flag tracks count against the low limit
    level_ok_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $stable(low_lim) |-> level_o == (cnt >= low_lim))
        else $error("level flag disagrees with count");

    // High flag tracks count against the high limit
    high_ok_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $stable(high_lim) |-> high_o == (cnt >= high_lim))
        else $error("high flag disagrees with count");

    // Reading the only mature entry drops valid even with young entries behind
    v_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        rd_acc && mature == 4'h1 && !wr_d2 |=> !valid_o)
        else $error("valid stayed high with only young entries");

    // Bus holds the last read value when valid falls
    q_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $fell(valid_o) |-> $stable(rd_data_o))
        else $error("output data changed when valid fell");

    // APB answers in the cycle after setup
    apb_ready_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        psel_i && !penable_i |=> pready_o)
        else $error("APB ready missing in access phase");

endmodule

//--- sim/tff_consumer.sv
`timescale 1ns/1ps
module tff_consumer (
    input  wire logic                       sys_clk_i,  // System clock
    input  wire logic                       rst_b_i,    // Sync reset, active low
    input  wire logic                       valid_i,    // Head valid
    input  wire logic [tff_pkg::DATA_W-1:0] data_i,     // Head data
    input  wire logic                       hold_i,     // Stall the consumer
    input  wire logic                       stray_i,    // Ack regardless of valid
    output logic                            rd_ack_o,   // Read acknowledge
    output logic      [tff_pkg::DATA_W-1:0] last_o,     // Last word taken
    output logic      [7:0]                 taken_o     // Words taken
);
    ////////////////////////////////////////////////////////////////////////////
    // Ack fed back from valid, not level, so no limit constraint applies
    assign rd_ack_o = (valid_i & ~hold_i) | stray_i;

    // Record each word taken; a stray ack takes nothing
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            last_o  <= '0;
            taken_o <= 8'h00;
        end else if (rd_ack_o && valid_i) begin
            last_o  <= data_i;
            taken_o <= taken_o + 8'h01;
        end
    end
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                       sys_clk;
    logic                       rst_b;
    logic                       wr;
    logic [tff_pkg::DATA_W-1:0] wr_data;
    logic                       wr_ready;
    logic                       rd_ack;
    logic [tff_pkg::DATA_W-1:0] rd_data;
    logic                       valid;
    logic                       level;
    logic                       high;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [11:0]                paddr;
    logic [31:0]                pwdata;
    logic [3:0]                 pstrb;
    logic [3:0]                 lanes;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       hold;
    logic                       stray;
    logic [tff_pkg::DATA_W-1:0] last;
    logic [7:0]                 taken;
    int                         err_count;
    int                         check_count;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 8 ns period
    always #4 sys_clk = ~sys_clk;

    tff_top dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .wr_i(wr), .wr_data_i(wr_data),
        .wr_ready_o(wr_ready), .rd_ack_i(rd_ack), .rd_data_o(rd_data), .valid_o(valid),
        .level_o(level), .high_o(high), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

    tff_consumer partner (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .valid_i(valid),
        .data_i(rd_data), .hold_i(hold), .stray_i(stray), .rd_ack_o(rd_ack),
        .last_o(last), .taken_o(taken));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; waits for pready as long as it takes, the watchdog ends a hang
    task automatic apb(input logic wr_en, input logic [11:0] addr, input logic [31:0] wdat,
                       output logic [31:0] rdat, output logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= addr;
        pwdata  <= wdat;
        pstrb   <= lanes;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        logic        e;
        #1;
        check(wr_ready, 1'b1);
        check({valid, level, high}, 3'b000);
        apb(1'b0, tff_pkg::CTRL_OFS, 32'h0, d, e);
        check(d, {20'h0, tff_pkg::HIGH_RST, 4'h0, tff_pkg::LOW_RST});
        apb(1'b0, tff_pkg::STATUS_OFS, 32'h0, d, e);
        check(d, 32'h0);
        apb(1'b1, 12'h008, 32'hffff_ffff, d, e);
        check(e, 1'b1);
        apb(1'b0, 12'h008, 32'h0, d, e);
        check({e, d}, {1'b1, 32'h0});
        // Only lane 0 enabled, so the high limit must keep its reset value
        lanes = 4'h1;
        apb(1'b1, tff_pkg::CTRL_OFS, 32'h0000_0f01, d, e);
        lanes = 4'hf;
        check(e, 1'b0);
        apb(1'b0, tff_pkg::CTRL_OFS, 32'h0, d, e);
        check(d, 32'h0000_0701);
        $display("test reset and registers done");
    endtask

    // Write into empty with low limit 1: level runs ahead of valid
    task automatic t_first();
        @(posedge sys_clk);
        wr      <= 1'b1;
        wr_data <= 16'h00a5;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
        check({level, valid}, 2'b10);
        @(posedge sys_clk);
        #1;
        check(valid, 1'b0);
        @(posedge sys_clk);
        #1;
        check(valid, 1'b1);
        check(rd_data, 16'h00a5);
        $display("test first write done");
    endtask

    // Read while the next word is still young: valid falls, data holds
    task automatic t_early();
        @(posedge sys_clk);
        wr      <= 1'b1;
        wr_data <= 16'h005a;
        @(posedge sys_clk);
        wr   <= 1'b0;
        hold <= 1'b0;
        @(posedge sys_clk);
        #1;
        check(valid, 1'b0);
        check(rd_data, 16'h00a5);
        check({last, level}, {16'h00a5, 1'b1});
        for (int n = 0; n < 8 && taken !== 8'h02; n++) @(posedge sys_clk);
        #1;
        check(last, 16'h005a);
        check({valid, level}, 2'b00);
        $display("test early read done");
    endtask

    // Back-to-back writes until the buffer refuses, consumer stalled
    task automatic t_fill();
        logic [31:0] d;
        logic        e;
        int          cnt;
        @(posedge sys_clk);
        hold <= 1'b1;
        apb(1'b1, tff_pkg::CTRL_OFS, 32'h0000_0703, d, e);
        for (int i = 0; i <= 9; i++) begin
            @(posedge sys_clk);
            wr      <= (i < 9);
            wr_data <= 16'h0100 + 16'(i);
            if (i > 0) begin
                #1;
                cnt = (i > 8) ? 8 : i;
                check(level, cnt >= 3);
                check(high, cnt >= 7);
                check(wr_ready, cnt < 8);
            end
        end
        repeat (4) @(posedge sys_clk);
        apb(1'b0, tff_pkg::STATUS_OFS, 32'h0, d, e);
        check(d, 32'h0008_0f08);
        $display("test fill done");
    endtask

    // Drain with the consumer stalling every other cycle
    task automatic t_drain();
        int idx;
        idx = 0;
        for (int n = 0; n < 64 && idx < 8; n++) begin
            @(posedge sys_clk);
            hold <= n[0];
            #1;
            if (rd_ack === 1'b1) begin
                check(rd_data, 16'h0100 + 16'(idx));
                idx++;
            end
        end
        @(posedge sys_clk);
        hold <= 1'b1;
        #1;
        check(idx, 8);
        check({valid, level, high, wr_ready}, 4'b0001);
        check(taken, 8'h0a);
        $display("test drain done");
    endtask

    // An ack while empty must change nothing
    task automatic t_stray();
        logic [31:0] d;
        logic        e;
        @(posedge sys_clk);
        stray <= 1'b1;
        repeat (2) @(posedge sys_clk);
        stray <= 1'b0;
        apb(1'b0, tff_pkg::STATUS_OFS, 32'h0, d, e);
        check(d, 32'h0);
        check({valid, taken}, {1'b0, 8'h0a});
        $display("test stray ack done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence, two reset cycles first
    initial begin
        {sys_clk, rst_b, wr, wr_data, psel, penable, pwrite, paddr, pwdata} = '0;
        {stray, err_count, check_count} = '0;
        {pstrb, lanes} = 8'hff;
        hold = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_first();
        t_early();
        t_fill();
        t_drain();
        t_stray();
        final_report();
    end

    // Watchdog, far beyond the fewer than one hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_count++;
        final_report();
    end
endmodule
